// ### design/ocr_defines.vh
// Register offsets, field positions and reset values of the output clock configuration bank.
`ifndef OCR_DEFINES_VH
`define OCR_DEFINES_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define OCR_ADDR_OUT3_SKEW 8'h2c
`define OCR_ADDR_OUT3_DRIVER 8'h2d
`define OCR_ADDR_OUT3_TERM 8'h2f
`define OCR_ADDR_OUT4_DIV_HIGH 8'h30
`define OCR_ADDR_OUT4_DIV_MID 8'h31
`define OCR_ADDR_OUT4_DIV_LOW 8'h32
`define OCR_ADDR_OUT4_PHASE 8'h33
// ****************************************************************
// Reset value
// ****************************************************************
`define OCR_RESET_VALUE 8'h00
`define OCR_FINE_STEPS_RESET 3'h0
`define OCR_DRV_SELECT_RESET 6'h01
// ****************************************************************
// Field positions
// ****************************************************************
`define OCR_DIV_HIGH_MSB 3
`define OCR_COARSE_MSB 5
`define OCR_FINE_MSB 7
`define OCR_FINE_LSB 6
`define OCR_FINE_EXT_BIT 4
`define OCR_SUPPLY_MSB 4
`define OCR_SUPPLY_LSB 3
`define OCR_DRV_STD_MSB 2
`define OCR_FUSE_MSB 7
`define OCR_FUSE_LSB 6
`define OCR_MODE_MSB 3
`define OCR_PHASE_MSB 7
`define OCR_PHASE_LSB 6
// ****************************************************************
// Codes
// ****************************************************************
`define OCR_MODE_EXT_TERM 4'h0
`define OCR_MODE_PULL_UP 4'h2
`define OCR_MODE_PULL_DOWN 4'h1
`define OCR_MODE_SE_POS 4'h4
`define OCR_MODE_SE_NEG 4'h8
`define OCR_MODE_SE_BOTH 4'hc
`define OCR_FINE_MAX_STEPS 3'h4
`define OCR_SUPPLY_1V8 2'h0
`define OCR_SUPPLY_2V5 2'h1
`define OCR_SUPPLY_3V3 2'h2
`endif

// ### design/ocr_mode_decode.v
// Decoder of the four-bit output mode field into termination and leg enables.
`timescale 1ns/1ps
`include "ocr_defines.vh"
module ocr_mode_decode
(
	input wire [3:0] mode_i,
	output reg ext_term_o,
	output reg pull_up_o,
	output reg pull_down_o,
	output reg se_pos_en_o,
	output reg se_neg_en_o,
	output reg mode_valid_o
);
	// ****************************************************************
	// Decode
	// ****************************************************************
	// Unlisted codes leave every driver off, so a bad write cannot short a leg.
	always @*
	begin
		ext_term_o = 1'b0;
		pull_up_o = 1'b0;
		pull_down_o = 1'b0;
		se_pos_en_o = 1'b0;
		se_neg_en_o = 1'b0;
		mode_valid_o = 1'b1;
		case (mode_i)
			`OCR_MODE_EXT_TERM: ext_term_o = 1'b1;
			`OCR_MODE_PULL_UP: pull_up_o = 1'b1;
			`OCR_MODE_PULL_DOWN: pull_down_o = 1'b1;
			`OCR_MODE_SE_POS: se_pos_en_o = 1'b1;
			`OCR_MODE_SE_NEG: se_neg_en_o = 1'b1;
			`OCR_MODE_SE_BOTH:
			begin
				se_pos_en_o = 1'b1;
				se_neg_en_o = 1'b1;
			end
			default: mode_valid_o = 1'b0;
		endcase
	end
endmodule // ocr_mode_decode

// ### design/ocr_regs.v
// Configuration register bank for two output clock channels.
// Overview of operation
// - Divider built from high nibble, mid, low bytes.
// - Coarse skew is six low bits, 0-63.
// - Fine skew code in bits 7:6, 30 ps steps.
// - Extra fine bit extends code to 0-4 steps.
// - Supply level code: 1.8, 2.5, 3.3 volts.
// - Three-bit driver standard code selects driver type.
// - Fuse written when two bits differ.
// - Differential termination: external, pull-up, pull-down.
// - Single-ended legs: positive, negative, or both.
// - Phase select routes true/complement to legs.
`timescale 1ns/1ps
`include "ocr_defines.vh"
module ocr_regs
(
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_rvalid_o,
	output wire [5:0] out3_output_skew_setting_o,
	output wire [2:0] out3_fine_skew_code_o,
	output reg [2:0] out3_fine_skew_steps_o,
	output wire [1:0] out3_output_supply_level_o,
	output wire [2:0] out3_output_driver_standard_o,
	output wire [5:0] out3_driver_select_o,
	output wire out3_fuse_written_o,
	output wire out3_ext_term_o,
	output wire out3_pull_up_o,
	output wire out3_pull_down_o,
	output wire out3_se_pos_en_o,
	output wire out3_se_neg_en_o,
	output wire out3_mode_valid_o,
	output wire [19:0] out4_output_divider_value_o,
	output wire out4_positive_leg_source_o,
	output wire out4_negative_leg_source_o
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	reg [7:0] output3_skew_control;
	reg [7:0] output3_driver_config;
	reg [7:0] output3_termination_mode;
	reg [7:0] output4_divider_high;
	reg [7:0] output4_divider_mid;
	reg [7:0] output4_divider_low;
	reg [7:0] output4_phase_select;
	reg [7:0] next_rdata;
	reg [2:0] next_fine_code;
	reg [2:0] next_drv_code;
	reg [5:0] drv_select;
	wire [2:0] reg_index;

	// One-hot driver select: bit n is code n; codes 6 and 7 select nothing.
	function [5:0] ocr_drv_onehot;
		input [2:0] code;
		begin
			case (code)
				3'h0: ocr_drv_onehot = 6'h01;
				3'h1: ocr_drv_onehot = 6'h02;
				3'h2: ocr_drv_onehot = 6'h04;
				3'h3: ocr_drv_onehot = 6'h08;
				3'h4: ocr_drv_onehot = 6'h10;
				3'h5: ocr_drv_onehot = 6'h20;
				default: ocr_drv_onehot = 6'h00;
			endcase
		end
	endfunction

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// Bank index of each mapped offset; the last code marks an unmapped offset.
	localparam [2:0] IDX_OUT3_SKEW = 3'h0;
	localparam [2:0] IDX_OUT3_DRIVER = 3'h1;
	localparam [2:0] IDX_OUT3_TERM = 3'h2;
	localparam [2:0] IDX_OUT4_DIV_HIGH = 3'h3;
	localparam [2:0] IDX_OUT4_DIV_MID = 3'h4;
	localparam [2:0] IDX_OUT4_DIV_LOW = 3'h5;
	localparam [2:0] IDX_OUT4_PHASE = 3'h6;
	localparam [2:0] IDX_NONE = 3'h7;

	// Shared by the write port, the read port and the pre-decoded outputs, so an offset
	// is decoded in one place only and the three can never disagree.
	function [2:0] ocr_reg_index;
		input [7:0] addr;
		begin
			case (addr)
				`OCR_ADDR_OUT3_SKEW: ocr_reg_index = IDX_OUT3_SKEW;
				`OCR_ADDR_OUT3_DRIVER: ocr_reg_index = IDX_OUT3_DRIVER;
				`OCR_ADDR_OUT3_TERM: ocr_reg_index = IDX_OUT3_TERM;
				`OCR_ADDR_OUT4_DIV_HIGH: ocr_reg_index = IDX_OUT4_DIV_HIGH;
				`OCR_ADDR_OUT4_DIV_MID: ocr_reg_index = IDX_OUT4_DIV_MID;
				`OCR_ADDR_OUT4_DIV_LOW: ocr_reg_index = IDX_OUT4_DIV_LOW;
				`OCR_ADDR_OUT4_PHASE: ocr_reg_index = IDX_OUT4_PHASE;
				default: ocr_reg_index = IDX_NONE;
			endcase
		end
	endfunction

	assign reg_index = ocr_reg_index(reg_addr_i);

	// ****************************************************************
	// Write port
	// ****************************************************************
	always @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			output3_skew_control <= `OCR_RESET_VALUE;
			output3_driver_config <= `OCR_RESET_VALUE;
			output3_termination_mode <= `OCR_RESET_VALUE;
			output4_divider_high <= `OCR_RESET_VALUE;
			output4_divider_mid <= `OCR_RESET_VALUE;
			output4_divider_low <= `OCR_RESET_VALUE;
			output4_phase_select <= `OCR_RESET_VALUE;
		end
		else if (reg_wr_i)
		begin
			case (reg_index)
				IDX_OUT3_SKEW: output3_skew_control <= reg_wdata_i;
				IDX_OUT3_DRIVER: output3_driver_config <= reg_wdata_i;
				IDX_OUT3_TERM: output3_termination_mode <= reg_wdata_i;
				IDX_OUT4_DIV_HIGH: output4_divider_high <= reg_wdata_i;
				IDX_OUT4_DIV_MID: output4_divider_mid <= reg_wdata_i;
				IDX_OUT4_DIV_LOW: output4_divider_low <= reg_wdata_i;
				IDX_OUT4_PHASE: output4_phase_select <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Unmapped offsets read as zero rather than aliasing a neighbour.
	always @*
	begin
		case (reg_index)
			IDX_OUT3_SKEW: next_rdata = output3_skew_control;
			IDX_OUT3_DRIVER: next_rdata = output3_driver_config;
			IDX_OUT3_TERM: next_rdata = output3_termination_mode;
			IDX_OUT4_DIV_HIGH: next_rdata = output4_divider_high;
			IDX_OUT4_DIV_MID: next_rdata = output4_divider_mid;
			IDX_OUT4_DIV_LOW: next_rdata = output4_divider_low;
			IDX_OUT4_PHASE: next_rdata = output4_phase_select;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end

	// ****************************************************************
	// Output three fields
	// ****************************************************************
	assign out3_output_skew_setting_o = output3_skew_control[`OCR_COARSE_MSB:0];
	// A zero extension bit leaves the plain two-bit code of 0-3 steps.
	assign out3_fine_skew_code_o = {output3_termination_mode[`OCR_FINE_EXT_BIT],
		output3_skew_control[`OCR_FINE_MSB:`OCR_FINE_LSB]};

	// ****************************************************************
	// Pre-decoded outputs
	// ****************************************************************
	// Decoded from the byte being written, so these outputs leave flip-flops and
	// still change on the same edge as the fields they are made from.
	always @*
	begin
		next_fine_code = out3_fine_skew_code_o;
		next_drv_code = out3_output_driver_standard_o;
		if (reg_wr_i && (reg_index == IDX_OUT3_SKEW))
			next_fine_code[1:0] = reg_wdata_i[`OCR_FINE_MSB:`OCR_FINE_LSB];
		if (reg_wr_i && (reg_index == IDX_OUT3_TERM))
			next_fine_code[2] = reg_wdata_i[`OCR_FINE_EXT_BIT];
		if (reg_wr_i && (reg_index == IDX_OUT3_DRIVER))
			next_drv_code = reg_wdata_i[`OCR_DRV_STD_MSB:0];
	end

	// Codes above four steps are outside the delay line, so they saturate.
	always @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			out3_fine_skew_steps_o <= `OCR_FINE_STEPS_RESET;
			drv_select <= `OCR_DRV_SELECT_RESET;
		end
		else
		begin
			out3_fine_skew_steps_o <= (next_fine_code > `OCR_FINE_MAX_STEPS) ?
				`OCR_FINE_MAX_STEPS : next_fine_code;
			drv_select <= ocr_drv_onehot(next_drv_code);
		end
	end

	assign out3_output_supply_level_o =
		output3_driver_config[`OCR_SUPPLY_MSB:`OCR_SUPPLY_LSB];
	assign out3_output_driver_standard_o = output3_driver_config[`OCR_DRV_STD_MSB:0];
	assign out3_driver_select_o = drv_select;
	assign out3_fuse_written_o = output3_termination_mode[`OCR_FUSE_MSB] ^
		output3_termination_mode[`OCR_FUSE_LSB];

	ocr_mode_decode u_mode_decode
	(
		.mode_i(output3_termination_mode[`OCR_MODE_MSB:0]),
		.ext_term_o(out3_ext_term_o),
		.pull_up_o(out3_pull_up_o),
		.pull_down_o(out3_pull_down_o),
		.se_pos_en_o(out3_se_pos_en_o),
		.se_neg_en_o(out3_se_neg_en_o),
		.mode_valid_o(out3_mode_valid_o)
	);

	// ****************************************************************
	// Output four fields
	// ****************************************************************
	assign out4_output_divider_value_o = {output4_divider_high[`OCR_DIV_HIGH_MSB:0],
		output4_divider_mid, output4_divider_low};
	// Bit 7 high selects the complement phase on the positive leg; bit 6 is inverted, so low selects it on the negative leg.
	assign out4_positive_leg_source_o = output4_phase_select[`OCR_PHASE_MSB];
	assign out4_negative_leg_source_o = ~output4_phase_select[`OCR_PHASE_LSB];
endmodule // ocr_regs

// ### tb/ocr_regs_properties.sv
// Concurrent checks of the configuration register bank at its ports.
`timescale 1ns/1ps
module ocr_regs_properties
(
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire reg_rvalid_o,
	input wire [5:0] out3_output_skew_setting_o,
	input wire [2:0] out3_fine_skew_code_o,
	input wire [2:0] out3_fine_skew_steps_o,
	input wire [1:0] out3_output_supply_level_o,
	input wire [2:0] out3_output_driver_standard_o,
	input wire [5:0] out3_driver_select_o,
	input wire out3_fuse_written_o,
	input wire out3_ext_term_o,
	input wire out3_se_pos_en_o,
	input wire [19:0] out4_output_divider_value_o,
	input wire out4_positive_leg_source_o,
	input wire out4_negative_leg_source_o
);
	// Offset 00 is unmapped, so it stands for no write at all.
	wire [7:0] wa = reg_wr_i ? reg_addr_i : 8'h00;
	wire [1:0] wd76 = reg_wdata_i[7:6];
	wire [3:0] wm = reg_wdata_i[3:0];
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ********
	// Assertions
	// ********
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	div_mid_a: assert property (wa == 8'h31 |=> out4_output_divider_value_o[15:8] == $past(reg_wdata_i))
		else $error("divider mid byte wrong");
	skew_set_a: assert property (wa == 8'h2c |=>
		{out3_fine_skew_code_o[1:0], out3_output_skew_setting_o} == $past(reg_wdata_i))
		else $error("skew fields wrong");
	fine_sat_a: assert property (out3_fine_skew_steps_o ==
		(out3_fine_skew_code_o > 3'h4 ? 3'h4 : out3_fine_skew_code_o)) else $error("fine steps wrong");
	drv_field_a: assert property (wa == 8'h2d |=> {3'h0, out3_output_supply_level_o,
		out3_output_driver_standard_o} == ($past(reg_wdata_i) & 8'h1f)) else $error("driver fields wrong");
	drv_onehot_a: assert property (out3_driver_select_o == (out3_output_driver_standard_o < 3'h6 ?
		6'h01 << out3_output_driver_standard_o : 6'h00)) else $error("driver select wrong");
	term_fuse_a: assert property (wa == 8'h2f |=>
		{out3_fuse_written_o, out3_ext_term_o} == {^$past(wd76), $past(wm) == 4'h0}) else $error("term wrong");
	se_pos_a: assert property (wa == 8'h2f |=>
		out3_se_pos_en_o == ($past(wm) == 4'h4 || $past(wm) == 4'hc)) else $error("leg enable wrong");
	phase_sel_a: assert property (wa == 8'h33 |=>
		{out4_positive_leg_source_o, !out4_negative_leg_source_o} == $past(wd76)) else $error("phase wrong");
	cover property (wa == 8'h2f ##1 out3_se_pos_en_o);
	cover property (out3_fine_skew_steps_o == 3'h4);
	cover property (reg_rd_i ##1 reg_rvalid_o);
endmodule // ocr_regs_properties

// ### tb/ocr_regs_test.sv
// Self-checking bench of the output clock configuration registers.
`timescale 1ns/1ps
module ocr_regs_test;
	logic clk_sys_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
	wire [7:0] reg_rdata_o;
	wire reg_rvalid_o, out3_fuse_written_o, out3_ext_term_o, out3_pull_up_o, out3_pull_down_o;
	wire out3_se_pos_en_o, out3_se_neg_en_o, out3_mode_valid_o, out4_positive_leg_source_o;
	wire out4_negative_leg_source_o;
	wire [5:0] out3_output_skew_setting_o, out3_driver_select_o;
	wire [2:0] out3_fine_skew_code_o, out3_fine_skew_steps_o, out3_output_driver_standard_o;
	wire [1:0] out3_output_supply_level_o;
	wire [19:0] out4_output_divider_value_o;
	logic [7:0] dut_map [7] = '{8'h2c, 8'h2d, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33};
	logic [3:0] modes [6] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc};
	int miscompares = 0, tests_run = 0, cycles = 0;
	ocr_regs dut
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.out3_output_skew_setting_o(out3_output_skew_setting_o),
		.out3_fine_skew_code_o(out3_fine_skew_code_o),
		.out3_fine_skew_steps_o(out3_fine_skew_steps_o),
		.out3_output_supply_level_o(out3_output_supply_level_o),
		.out3_output_driver_standard_o(out3_output_driver_standard_o),
		.out3_driver_select_o(out3_driver_select_o),
		.out3_fuse_written_o(out3_fuse_written_o),
		.out3_ext_term_o(out3_ext_term_o),
		.out3_pull_up_o(out3_pull_up_o),
		.out3_pull_down_o(out3_pull_down_o),
		.out3_se_pos_en_o(out3_se_pos_en_o),
		.out3_se_neg_en_o(out3_se_neg_en_o),
		.out3_mode_valid_o(out3_mode_valid_o),
		.out4_output_divider_value_o(out4_output_divider_value_o),
		.out4_positive_leg_source_o(out4_positive_leg_source_o),
		.out4_negative_leg_source_o(out4_negative_leg_source_o)
	);
	always #50 clk_sys_i = ~clk_sys_i;
	task check(input string n, input logic [19:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clk_sys_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} = {1'h1, a, d};
		@(negedge clk_sys_i);
		reg_wr_i = 1'h0;
	endtask
	task rd(input logic [7:0] a, e);
		@(negedge clk_sys_i);
		{reg_rd_i, reg_addr_i} = {1'h1, a};
		@(negedge clk_sys_i);
		reg_rd_i = 1'h0;
		check("rvalid", reg_rvalid_o, 1'h1);
		check("rdata", reg_rdata_o, e);
	endtask
	// ********
	// Scenarios
	// ********
	task do_reset;
		@(negedge clk_sys_i);
		rst_n_i = 1'h0;
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'h1;
		check("reset", {out4_output_divider_value_o[11:0],
			out3_driver_select_o, out3_ext_term_o, out4_negative_leg_source_o}, 20'h0_0007);
		foreach (dut_map[i]) rd(dut_map[i], 8'h00);
	endtask
	task t_div;
		wr(8'h30, 8'hf5);
		wr(8'h31, 8'hab);
		wr(8'h32, 8'hcd);
		check("divider", out4_output_divider_value_o, 20'h5_abcd);
		rd(8'h30, 8'hf5);
		wr(8'h2e, 8'hff);
		rd(8'h2e, 8'h00);
	endtask
	task t_fields;
		logic [1:0] s;
		for (int i = 0; i < 8; i++)
		begin
			s = 2'(i % 3);
			wr(8'h2c, {i[1:0], 6'h3f ^ i[5:0]});
			wr(8'h2f, {3'h0, i[2], 4'h0});
			wr(8'h2d, {3'h0, s, i[2:0]});
			check("coarse", out3_output_skew_setting_o, 6'h3f ^ i[5:0]);
			check("fine code", out3_fine_skew_code_o, i[2:0]);
			check("fine steps", out3_fine_skew_steps_o, i[2:0] > 3'h4 ? 3'h4 : i[2:0]);
			check("supply", out3_output_supply_level_o, s);
			check("standard", out3_output_driver_standard_o, i[2:0]);
			check("driver", out3_driver_select_o, i < 6 ? 6'h01 << i : 6'h00);
		end
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h2f, {i[1:0], 2'h0, modes[i]});
			check("fuse", out3_fuse_written_o, ^i[1:0]);
			check("term", {out3_mode_valid_o, out3_ext_term_o,
				out3_pull_up_o, out3_pull_down_o},
				{1'h1, modes[i] == 4'h0, modes[i] == 4'h2, modes[i] == 4'h1});
			check("legs", {out3_se_pos_en_o, out3_se_neg_en_o}, {modes[i][2], modes[i][3]});
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h33, {i[1:0], 6'h00});
			check("phase", {out4_positive_leg_source_o,
				out4_negative_leg_source_o}, {i[1], ~i[0]});
		end
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// The whole run needs about 115 cycles, so 3000 means a hang.
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			close_out;
		end
	end
	initial
	begin
		do_reset;
		t_div;
		t_fields;
		do_reset;
		close_out;
	end
endmodule // ocr_regs_test
bind ocr_regs ocr_regs_properties u_chk (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rvalid_o, .out3_output_skew_setting_o, .out3_fine_skew_code_o,
	.out3_fine_skew_steps_o, .out3_output_supply_level_o, .out3_output_driver_standard_o,
	.out3_driver_select_o, .out3_fuse_written_o, .out3_ext_term_o, .out3_se_pos_en_o,
	.out4_output_divider_value_o, .out4_positive_leg_source_o, .out4_negative_leg_source_o);
